// File: design/gfd_consts.vh
// Purpose: Constants for the genset fault detector.
// Assumes: 200 MHz mclk, 1 ms timer tick.
// Notes:   Time figures in their own unit, counts derived from them.
`ifndef GFD_CONSTS_VH
`define GFD_CONSTS_VH

// ****************************************
// Clock and tick timing
// ****************************************
`define GFD_CLK_PS        5000
`define GFD_TICK_PS       1000000000
`define GFD_TICK_CYC      (`GFD_TICK_PS / `GFD_CLK_PS)
`define GFD_TICK_MS       1

// ****************************************
// Fixed delays, in ms and in ticks
// ****************************************
`define GFD_ECU_SILENT_MS 3000
`define GFD_BTN_HOLD_MS   5000
`define GFD_ECU_SILENT_TK (`GFD_ECU_SILENT_MS / `GFD_TICK_MS)
`define GFD_BTN_HOLD_TK   (`GFD_BTN_HOLD_MS / `GFD_TICK_MS)

// ****************************************
// Fault vector bit positions
// ****************************************
`define GFD_F_ECU_SILENT  0
`define GFD_F_LOW_CHARGE  1
`define GFD_F_VOLT_UNBAL  2
`define GFD_F_CURR_UNBAL  3
`define GFD_F_OVERCURR    4
`define GFD_F_SPEED_LOSS  5
`define GFD_F_SERVICE     6
`define GFD_F_ECU_LINK    7
`define GFD_F_OVERLOAD    8
`define GFD_F_REV_POWER   9
`define GFD_F_PHASE_ORDER 10
`define GFD_F_MAINS_OPEN  11
`define GFD_F_GEN_CLOSE   12
`define GFD_F_LOCKED      13
`define GFD_F_TOPOLOGY    14
`define GFD_F_EXCITATION  15
`define GFD_NF            16

// Faults that are always load dumps; bits 2..6 follow the action inputs
`define GFD_LD_FIXED      16'hff00
`define GFD_ACT_LSB       2

// ****************************************
// Delay timer indices
// ****************************************
`define GFD_T_ECU         0
`define GFD_T_VU          1
`define GFD_T_CU          2
`define GFD_T_SPD         3
`define GFD_T_OVL         4
`define GFD_T_REV         5
`define GFD_T_MCB         6
`define GFD_T_GCB         7
`define GFD_T_HOLD        8
`define GFD_T_COOL        9
`define GFD_T_BTN         10
`define GFD_NT            11

`endif

// File: design/gfd_persist.v
// Purpose: Persistence timer: fires once a condition held for lim ticks.
// Assumes: tick is a one-cycle pulse.
// Notes:   A limit of zero fires as soon as the condition is seen.
`timescale 1ns/1ps

module gfd_persist (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Timing
    input  wire        tick,
    input  wire        cond,
    input  wire [15:0] lim,
    // Result
    output wire        done
);

    reg  [15:0] cnt_q;

    // ****************************************
    // Count ticks while the condition holds
    // ****************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0;
        end else if (!cond) begin
            cnt_q <= 16'h0;           // Restart on any gap
        end else if (tick && cnt_q < lim) begin
            cnt_q <= cnt_q + 16'h1;
        end
    end

    assign done = cond && (cnt_q >= lim);

endmodule

// File: design/gfd_tick.v
// Purpose: Prescaler giving a one-cycle pulse every millisecond.
// Assumes: TICK_CYCLES is the number of mclk cycles per tick.
// Notes:   Shorten TICK_CYCLES in simulation.
`timescale 1ns/1ps
`include "gfd_consts.vh"

module gfd_tick #(
    parameter TICK_CYCLES = `GFD_TICK_CYC
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Tick out
    output reg         tick_q
);

    reg  [17:0] cnt_q;

    // ****************************************
    // Free-running divider
    // ****************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q  <= 18'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == TICK_CYCLES[17:0] - 18'h1) begin
            cnt_q  <= 18'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 18'h1;
            tick_q <= 1'b0;
        end
    end

endmodule

// File: design/gfd_top.v
// Purpose: Genset fault detector, warnings and load-dump alarms.
// Assumes: Measurements are unsigned and synchronous to mclk;
//          power is signed. Delay limits are in milliseconds.
// Notes:   Alarms latch first-come and clear on alarm_clear.
//
// What this block does
// - Warn after 3 s engine controller silence
// - Silence checked only while fuel is on
// - Warn when charge voltage below limit
// - Running faults wait for holdoff after running
// - Voltage unbalance persisting for fail time
// - Current unbalance persisting, programmable action
// - Overcurrent inverse-time timer raises alarm on expiry
// - Currents back below limit abandon timing
// - Speed below crank cut for loss time
// - Service request when any counter expired
// - Two buttons held 5 s reset counters
// - Warn when engine controller link lost
// - Overload power persisting raises load dump
// - Reverse power persisting raises load dump
// - Reversed phase order, when enabled, dumps load
// - Breaker feedback missing by fail timer alarms
// - Remote lock raises load dump
// - Unknown topology after holdoff raises alarm
// - Excitation drive at limit on load alarms
// - Load dump opens contactor, stops after cooldown
// - First alarm blocks later same-or-lower alarms
`timescale 1ns/1ps
`include "gfd_consts.vh"

module gfd_top #(
    parameter TICK_CYCLES = `GFD_TICK_CYC
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Engine state
    input  wire        fuel_on,
    input  wire        engine_running,
    // Engine controller link
    input  wire        ecu_msg_rx,
    input  wire        ecu_link_lost,
    // Generator measurements
    input  wire [15:0] volt_l1,
    input  wire [15:0] volt_l2,
    input  wire [15:0] volt_l3,
    input  wire [15:0] curr_l1,
    input  wire [15:0] curr_l2,
    input  wire [15:0] curr_l3,
    input  wire [15:0] power_kw,
    input  wire [15:0] charge_volt,
    input  wire [15:0] pickup_rpm,
    input  wire        phase_reversed,
    // Programmed limits
    input  wire [15:0] charge_low_lim,
    input  wire [15:0] volt_unbal_lim,
    input  wire [15:0] curr_unbal_lim,
    input  wire [15:0] overcurr_lim,
    input  wire [23:0] inverse_time_curve,
    input  wire [15:0] crank_cut_rpm,
    input  wire [15:0] overload_lim,
    input  wire [15:0] rev_power_lim,
    // Programmed delays in ms
    input  wire [15:0] holdoff_ms,
    input  wire [15:0] volt_fail_ms,
    input  wire [15:0] speed_loss_persist_time,
    input  wire [15:0] overload_ms,
    input  wire [15:0] rev_power_ms,
    input  wire [15:0] contactor_fail_ms,
    input  wire [15:0] cooldown_ms,
    // Options; action bits: 1 = load dump, 0 = warning
    input  wire [4:0]  fault_action,
    input  wire        phase_check_en,
    input  wire        topo_auto_en,
    input  wire        topo_identified,
    // Breakers
    input  wire        mains_fb_defined,
    input  wire        mains_open_cmd,
    input  wire        mains_closed_fb,
    input  wire        gen_fb_defined,
    input  wire        gen_close_cmd,
    input  wire        gen_closed_fb,
    // Excitation
    input  wire [7:0]  excitation_drive_output,
    input  wire [7:0]  exc_min,
    input  wire [7:0]  exc_max,
    input  wire        gen_on_load,
    // Service and operator
    input  wire [2:0]  svc_expired,
    input  wire        btn_mute,
    input  wire        btn_lamp_test,
    input  wire        unit_locked,
    input  wire        alarm_clear,
    // Alarm outputs
    output reg  [15:0] warn_flags_q,
    output reg  [15:0] ld_flags_q,
    output reg         warning_lamp_q,
    output reg         alarm_lamp_q,
    output reg         alarm_out_q,
    output reg         contactor_release_q,
    output reg         engine_stop_q,
    output reg         svc_request_q,
    output reg         svc_reset_q,
    output reg         svc_done_msg_q
);

    // ****************************************
    // Helpers
    // ****************************************
    // True when any of three values strays from their mean by more than lim
    function unbal;
        input [15:0] a;
        input [15:0] b;
        input [15:0] c;
        input [15:0] lim;
        reg   [17:0] sum, tl, da, db, dc;
        begin
            sum = {2'b00, a} + {2'b00, b} + {2'b00, c};
            tl  = {2'b00, lim} + {1'b0, lim, 1'b0};
            da  = {2'b00, a} + {1'b0, a, 1'b0};
            db  = {2'b00, b} + {1'b0, b, 1'b0};
            dc  = {2'b00, c} + {1'b0, c, 1'b0};
            da  = (da > sum) ? da - sum : sum - da;
            db  = (db > sum) ? db - sum : sum - db;
            dc  = (dc > sum) ? dc - sum : sum - dc;
            unbal = (da > tl) || (db > tl) || (dc > tl);
        end
    endfunction

    // ****************************************
    // Millisecond tick and delay timers
    // ****************************************
    wire                  tick;
    wire [`GFD_NT-1:0]    t_cond;
    wire [`GFD_NT*16-1:0] t_lim;
    wire [`GFD_NT-1:0]    t_done;
    localparam [15:0] ECU_LIM = `GFD_ECU_SILENT_TK;
    localparam [15:0] BTN_LIM = `GFD_BTN_HOLD_TK;

    gfd_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk   (mclk),
        .reset  (reset),
        .tick_q (tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `GFD_NT; gi = gi + 1) begin : g_tmr
            gfd_persist u_persist (
                .mclk  (mclk),
                .reset (reset),
                .tick  (tick),
                .cond  (t_cond[gi]),
                .lim   (t_lim[gi*16 +: 16]),
                .done  (t_done[gi])
            );
        end
    endgenerate

    // ****************************************
    // Conditions
    // ****************************************
    wire        run_ok;
    wire        oc_any;
    wire [15:0] curr_max;
    wire [15:0] oc_excess;
    wire        pwr_neg;
    wire [15:0] pwr_mag;
    wire        ld_active;
    wire        warn_active;

    // Running faults wait for the holdoff after running
    assign run_ok = t_done[`GFD_T_HOLD];

    assign oc_any = (curr_max > overcurr_lim);
    assign curr_max = (curr_l1 > curr_l2) ?
                      ((curr_l1 > curr_l3) ? curr_l1 : curr_l3) :
                      ((curr_l2 > curr_l3) ? curr_l2 : curr_l3);
    assign oc_excess = oc_any ? curr_max - overcurr_lim : 16'h0;

    assign pwr_neg = power_kw[15];
    assign pwr_mag = pwr_neg ? (16'h0 - power_kw) : power_kw;

    assign ld_active   = |ld_flags_q;
    assign warn_active = |warn_flags_q;

    // Timer conditions
    assign t_cond[`GFD_T_ECU]  = fuel_on && !ecu_msg_rx;
    assign t_cond[`GFD_T_VU]   = run_ok &&
        unbal(volt_l1, volt_l2, volt_l3, volt_unbal_lim);
    assign t_cond[`GFD_T_CU]   = run_ok &&
        unbal(curr_l1, curr_l2, curr_l3, curr_unbal_lim);
    assign t_cond[`GFD_T_SPD]  = fuel_on && (pickup_rpm < crank_cut_rpm);
    assign t_cond[`GFD_T_OVL]  = !pwr_neg && (power_kw > overload_lim);
    assign t_cond[`GFD_T_REV]  = pwr_neg && (pwr_mag > rev_power_lim);
    assign t_cond[`GFD_T_MCB]  = mains_fb_defined && mains_open_cmd && mains_closed_fb;
    assign t_cond[`GFD_T_GCB]  = gen_fb_defined && gen_close_cmd && !gen_closed_fb;
    assign t_cond[`GFD_T_HOLD] = engine_running;
    assign t_cond[`GFD_T_COOL] = ld_active;
    assign t_cond[`GFD_T_BTN]  = btn_mute && btn_lamp_test;

    // Timer limits in ticks
    assign t_lim[`GFD_T_ECU*16 +: 16]  = ECU_LIM;
    assign t_lim[`GFD_T_VU*16 +: 16]   = volt_fail_ms;
    assign t_lim[`GFD_T_CU*16 +: 16]   = volt_fail_ms;
    assign t_lim[`GFD_T_SPD*16 +: 16]  = speed_loss_persist_time;
    assign t_lim[`GFD_T_OVL*16 +: 16]  = overload_ms;
    assign t_lim[`GFD_T_REV*16 +: 16]  = rev_power_ms;
    assign t_lim[`GFD_T_MCB*16 +: 16]  = contactor_fail_ms;
    assign t_lim[`GFD_T_GCB*16 +: 16]  = contactor_fail_ms;
    assign t_lim[`GFD_T_HOLD*16 +: 16] = holdoff_ms;
    assign t_lim[`GFD_T_COOL*16 +: 16] = cooldown_ms;
    assign t_lim[`GFD_T_BTN*16 +: 16]  = BTN_LIM;

    // ****************************************
    // Inverse-time overcurrent accumulator
    // ****************************************
    // Adds the excess each tick, so higher excess expires sooner
    reg  [23:0] oc_acc_q;
    wire [24:0] oc_sum;

    assign oc_sum = {1'b0, oc_acc_q} + {9'h0, oc_excess};

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            oc_acc_q <= 24'h0;
        end else if (!oc_any) begin
            oc_acc_q <= 24'h0;
        end else if (tick && oc_acc_q < inverse_time_curve) begin
            oc_acc_q <= oc_sum[24] ? 24'hffffff : oc_sum[23:0];
        end
    end

    // ****************************************
    // Fault vector and classification
    // ****************************************
    wire [15:0] flt;
    wire [15:0] ld_mask;
    wire [15:0] ld_new;
    wire [15:0] warn_new;

    assign flt[`GFD_F_ECU_SILENT]  = t_done[`GFD_T_ECU];
    assign flt[`GFD_F_LOW_CHARGE]  = run_ok && (charge_volt < charge_low_lim);
    assign flt[`GFD_F_VOLT_UNBAL]  = t_done[`GFD_T_VU];
    assign flt[`GFD_F_CURR_UNBAL]  = t_done[`GFD_T_CU];
    assign flt[`GFD_F_OVERCURR]    = oc_any && (oc_acc_q >= inverse_time_curve);
    assign flt[`GFD_F_SPEED_LOSS]  = t_done[`GFD_T_SPD];
    assign flt[`GFD_F_SERVICE]     = |svc_expired;
    assign flt[`GFD_F_ECU_LINK]    = ecu_link_lost;
    assign flt[`GFD_F_OVERLOAD]    = t_done[`GFD_T_OVL];
    assign flt[`GFD_F_REV_POWER]   = t_done[`GFD_T_REV];
    assign flt[`GFD_F_PHASE_ORDER] = phase_check_en && phase_reversed;
    assign flt[`GFD_F_MAINS_OPEN]  = t_done[`GFD_T_MCB];
    assign flt[`GFD_F_GEN_CLOSE]   = t_done[`GFD_T_GCB];
    assign flt[`GFD_F_LOCKED]      = unit_locked;
    assign flt[`GFD_F_TOPOLOGY]    = topo_auto_en && run_ok && !topo_identified;
    assign flt[`GFD_F_EXCITATION]  = gen_on_load &&
        ((excitation_drive_output <= exc_min) || (excitation_drive_output >= exc_max));

    // Programmable faults pick their level from the action bits
    assign ld_mask  = `GFD_LD_FIXED | {9'h0, fault_action, 2'b00};
    assign ld_new   = flt & ld_mask;
    assign warn_new = flt & ~ld_mask;

    // ****************************************
    // First-occurring alarm latches
    // ****************************************
    // A new event in the clearing cycle is still caught
    reg  [15:0] ld_d;
    reg  [15:0] warn_d;

    always @* begin
        if (alarm_clear || !ld_active) begin
            ld_d = ld_new;
        end else begin
            ld_d = ld_flags_q;
        end
        if (alarm_clear) begin
            warn_d = (|ld_new) ? 16'h0 : warn_new;
        end else if (ld_active || warn_active) begin
            warn_d = warn_flags_q;
        end else begin
            warn_d = (|ld_new) ? 16'h0 : warn_new;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ld_flags_q   <= 16'h0;
            warn_flags_q <= 16'h0;
        end else begin
            ld_flags_q   <= ld_d;
            warn_flags_q <= warn_d;
        end
    end

    // ****************************************
    // Alarm actions
    // ****************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            alarm_lamp_q        <= 1'b0;
            warning_lamp_q      <= 1'b0;
            alarm_out_q         <= 1'b0;
            contactor_release_q <= 1'b0;
            engine_stop_q       <= 1'b0;
        end else begin
            alarm_lamp_q        <= |ld_d;
            warning_lamp_q      <= |warn_d;
            alarm_out_q         <= (|ld_d) || (|warn_d);
            contactor_release_q <= |ld_d;
            engine_stop_q       <= t_done[`GFD_T_COOL];
        end
    end

    // ****************************************
    // Service request and counter reset
    // ****************************************
    reg         btn_done_q;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            btn_done_q     <= 1'b0;
            svc_reset_q    <= 1'b0;
            svc_done_msg_q <= 1'b0;
            svc_request_q  <= 1'b0;
        end else begin
            btn_done_q     <= t_done[`GFD_T_BTN];
            svc_reset_q    <= t_done[`GFD_T_BTN] && !btn_done_q;
            svc_done_msg_q <= t_done[`GFD_T_BTN];
            svc_request_q  <= |svc_expired;
        end
    end

endmodule

// File: dv/gfd_chk.sv
// Purpose: Concurrent checks on the fault detector outputs.
// Assumes: One mclk domain, reset asynchronous and active high.
// Notes:   Bound to every gfd_top instance.
`timescale 1ns/1ps

module gfd_chk (
    // Clock and reset
    input wire        mclk,
    input wire        reset,
    // Watched inputs
    input wire        fuel_on,
    input wire        ecu_msg_rx,
    input wire        phase_reversed,
    input wire        phase_check_en,
    input wire [7:0]  excitation_drive_output,
    input wire [7:0]  exc_min,
    input wire [7:0]  exc_max,
    input wire        gen_on_load,
    input wire [2:0]  svc_expired,
    input wire        btn_mute,
    input wire        btn_lamp_test,
    input wire        unit_locked,
    input wire        alarm_clear,
    // Watched outputs
    input wire [15:0] warn_flags_q,
    input wire [15:0] ld_flags_q,
    input wire        alarm_lamp_q,
    input wire        alarm_out_q,
    input wire        contactor_release_q,
    input wire        engine_stop_q,
    input wire        svc_request_q,
    input wire        svc_done_msg_q
);
    // ****************************************
    // Output relations, all on mclk
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Load dump lights the lamp and drops the contactor at once; stop waits for cooldown
    ld_outputs_a: assert property ($rose(|ld_flags_q) |-> alarm_lamp_q && contactor_release_q)
        else $error("load dump without lamp or contactor release");
    stop_delay_a: assert property ($rose(|ld_flags_q) |-> !engine_stop_q)
        else $error("engine stop without cooldown");
    stop_cause_a: assert property (engine_stop_q |-> $past(|ld_flags_q))
        else $error("engine stop with no load dump");
    alarm_out_a: assert property (alarm_out_q == ((|ld_flags_q) || (|warn_flags_q)))
        else $error("alarm output does not follow flags");
    // Latched load dumps hold until cleared
    ld_hold_a: assert property ((|ld_flags_q) && !alarm_clear |=> ld_flags_q == $past(ld_flags_q))
        else $error("load dump flags changed without clear");
    locked_ld_a: assert property (unit_locked && ld_flags_q == 16'h0000 |=> ld_flags_q[13])
        else $error("locked state not flagged");
    phase_ld_a: assert property (phase_check_en && phase_reversed && ld_flags_q == 16'h0000
        |=> ld_flags_q[10])
        else $error("reversed phase order not flagged");
    exc_lost_a: assert property (gen_on_load && (excitation_drive_output <= exc_min
        || excitation_drive_output >= exc_max) && ld_flags_q == 16'h0000 |=> ld_flags_q[15])
        else $error("excitation loss not flagged");
    fuel_gate_a: assert property (!fuel_on |=> !$rose(warn_flags_q[0]))
        else $error("silence warning with fuel off");
    msg_restart_a: assert property (ecu_msg_rx |=> !$rose(warn_flags_q[0]))
        else $error("silence warning right after a message");
    svc_req_a: assert property (svc_request_q == $past(|svc_expired))
        else $error("service request does not follow counters");
    svc_msg_a: assert property (svc_done_msg_q |-> $past(btn_mute && btn_lamp_test))
        else $error("completion message without both buttons");
endmodule

bind gfd_top gfd_chk gfd_chk_inst (
    .mclk, .reset, .fuel_on, .ecu_msg_rx, .phase_reversed, .phase_check_en,
    .excitation_drive_output, .exc_min, .exc_max, .gen_on_load, .svc_expired, .btn_mute,
    .btn_lamp_test, .unit_locked, .alarm_clear, .warn_flags_q, .ld_flags_q, .alarm_lamp_q,
    .alarm_out_q, .contactor_release_q, .engine_stop_q, .svc_request_q, .svc_done_msg_q
);

// File: dv/gfd_ecu_model.sv
// Purpose: Engine controller stand-in sending periodic messages.
// Assumes: One message is a one-cycle strobe.
// Notes:   Silent while send_en is low.
`timescale 1ns/1ps

module gfd_ecu_model #(
    parameter PERIOD = 1000
) (
    // Clock and reset
    input  wire mclk,
    input  wire reset,
    // Control
    input  wire send_en,
    // Message strobe
    output reg  ecu_msg_rx
);
    reg [15:0] gap_q;
    // Strobe once every PERIOD cycles while sending
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            gap_q      <= 16'h0000;
            ecu_msg_rx <= 1'b0;
        end else begin
            ecu_msg_rx <= send_en && (gap_q == PERIOD - 1);
            gap_q      <= (!send_en || gap_q == PERIOD - 1) ? 16'h0000 : gap_q + 16'h0001;
        end
    end
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the genset fault detector.
// Assumes: TICK_CYCLES of 4, so one ms is four mclk cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps

module testbench;
    reg        mclk = 1'b0, reset = 1'b1, send_en = 1'b0;
    reg        fuel_on = 1'b0, engine_running = 1'b0, ecu_link_lost = 1'b0;
    reg        phase_reversed = 1'b0, phase_check_en = 1'b0, topo_auto_en = 1'b0;
    reg        topo_identified = 1'b0, gen_on_load = 1'b0, unit_locked = 1'b0;
    reg        mains_fb_defined = 1'b0, mains_open_cmd = 1'b0, mains_closed_fb = 1'b0;
    reg        gen_fb_defined = 1'b0, gen_close_cmd = 1'b0, gen_closed_fb = 1'b0;
    reg        btn_mute = 1'b0, btn_lamp_test = 1'b0, alarm_clear = 1'b0;
    reg [15:0] volt_l1 = 16'h0000, volt_l2 = 16'h0000, volt_l3 = 16'h0000;
    reg [15:0] curr_l1 = 16'h0000, curr_l2 = 16'h0000, curr_l3 = 16'h0000;
    reg [15:0] power_kw = 16'h0000, charge_volt = 16'h0000, pickup_rpm = 16'h0000;
    reg [15:0] charge_low_lim = 16'h0000, volt_unbal_lim = 16'h000a, curr_unbal_lim = 16'h000a;
    reg [15:0] overcurr_lim = 16'h0064, crank_cut_rpm = 16'h0000, overload_lim = 16'h0064;
    reg [15:0] rev_power_lim = 16'h0064, holdoff_ms = 16'h0019, volt_fail_ms = 16'h0005;
    reg [15:0] speed_loss_persist_time = 16'h0005, overload_ms = 16'h000a;
    reg [15:0] rev_power_ms = 16'h000a, contactor_fail_ms = 16'h0005, cooldown_ms = 16'h0014;
    reg [23:0] inverse_time_curve = 24'h000190;
    reg [7:0]  excitation_drive_output = 8'h64, exc_min = 8'h0a, exc_max = 8'hc8;
    reg [4:0]  fault_action = 5'h0c;
    reg [2:0]  svc_expired = 3'h0;
    wire        ecu_msg_rx, warning_lamp_q, alarm_lamp_q, alarm_out_q, contactor_release_q;
    wire        engine_stop_q, svc_request_q, svc_reset_q, svc_done_msg_q;
    wire [15:0] warn_flags_q, ld_flags_q;
    int         fail_count = 0, checked = 0, resets = 0, i;
    // Expected {ld, warn} flags for each single-fault table entry
    reg [31:0]  exp_t [0:9] = '{32'h0, 32'h04000000, 32'h20000000, 32'h80000000, 32'h08000000,
                               32'h10000000, 32'h00200000, 32'h02000000, 32'h00000080, 32'h40000000};

    gfd_ecu_model #(.PERIOD(1000)) gfd_ecu_model_inst (.*);
    gfd_top #(.TICK_CYCLES(4)) gfd_top_inst (.*);

    // ****************************************
    // Clock, pulse counter and helper tasks
    // ****************************************
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // Counts service reset pulses
    always @(posedge mclk) begin
        if (svc_reset_q === 1'b1) resets = resets + 1;
    end
    task step(input int n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask
    task chk(input reg [31:0] exp, input reg [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t exp %h got %h", $time, exp, got);
            end
        end
    endtask
    // Pulse alarm_clear with all fault causes removed
    task clr;
        begin
            alarm_clear = 1'b1;
            step(1);
            alarm_clear = 1'b0;
            step(2);
            chk(32'h0, {ld_flags_q, warn_flags_q});
        end
    endtask
    // Raises or removes the cause of one table fault
    task apply(input int k, input reg v);
        begin
            case (k)
                0: phase_reversed = v;
                1: {phase_check_en, phase_reversed} = {2{v}};
                2: unit_locked = v;
                3: {gen_on_load, excitation_drive_output} = {v, v ? 8'h0a : 8'h64};
                4: {mains_fb_defined, mains_open_cmd, mains_closed_fb} = {3{v}};
                5: {gen_fb_defined, gen_close_cmd} = {2{v}};
                6: {fuel_on, crank_cut_rpm} = {v, v ? 16'h0064 : 16'h0000};
                7: power_kw = v ? 16'hff9b : 16'h0000;
                8: ecu_link_lost = v;
                default: {topo_auto_en, engine_running} = {2{v}};
            endcase
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #450000;
        fail_count = fail_count + 1;
        print_verdict;
    end
    initial begin
        step(16);
        reset = 1'b0;
        step(13000);
        chk(32'h0, {ld_flags_q, warn_flags_q});
        fuel_on = 1'b1;
        send_en = 1'b1;
        step(20000);
        chk(32'h0, {ld_flags_q, warn_flags_q});
        for (i = 0; i < 1100 && ecu_msg_rx !== 1'b1; i++) step(1);
        send_en = 1'b0;
        step(11990);
        chk(16'h0000, warn_flags_q);
        step(20);
        chk({16'h0001, 2'b11}, {warn_flags_q, warning_lamp_q, alarm_out_q});
        fuel_on = 1'b0;
        clr();
        $display("test silence done");
        for (i = 0; i < 2; i++) begin
            power_kw = 16'h0065;
            step(30);
            power_kw = 16'h0000;
            step(1);
        end
        chk(16'h0000, ld_flags_q);
        power_kw = 16'h0065;
        step(50);
        chk({16'h0100, 3'b110}, {ld_flags_q, contactor_release_q, alarm_lamp_q, engine_stop_q});
        unit_locked = 1'b1;
        step(100);
        chk({16'h0100, 1'b1}, {ld_flags_q, engine_stop_q});
        {unit_locked, power_kw} = 17'h0;
        clr();
        $display("test overload done");
        for (i = 0; i < 2; i++) begin
            curr_l1 = 16'h006e;
            step(100);
            curr_l1 = 16'h0000;
            step(1);
        end
        chk(16'h0000, ld_flags_q);
        curr_l1 = 16'h006e;
        step(150);
        chk(16'h0000, ld_flags_q);
        step(20);
        chk(16'h0010, ld_flags_q);
        curr_l1 = 16'h0000;
        clr();
        curr_l1 = 16'h008c;
        step(34);
        chk(16'h0000, ld_flags_q);
        step(10);
        chk(16'h0010, ld_flags_q);
        curr_l1 = 16'h0000;
        clr();
        $display("test overcurrent done");
        charge_low_lim = 16'h0064;
        engine_running = 1'b1;
        step(90);
        chk(16'h0000, warn_flags_q);
        step(20);
        chk(16'h0002, warn_flags_q);
        {volt_l1, curr_l1} = {16'h012c, 16'h0032};
        step(40);
        chk(32'h00000002, {ld_flags_q, warn_flags_q});
        fault_action = 5'h0f;
        step(40);
        chk(32'h000c0002, {ld_flags_q, warn_flags_q});
        {engine_running, volt_l1, curr_l1, charge_low_lim, fault_action} = {49'h0, 5'h0c};
        clr();
        $display("test running faults done");
        svc_expired = 3'h2;
        step(5);
        chk({16'h0040, 1'b1}, {warn_flags_q, svc_request_q});
        {btn_mute, btn_lamp_test} = 2'b11;
        step(19990);
        chk(32'h0, {svc_done_msg_q, resets[7:0]});
        step(20);
        chk(9'h101, {svc_done_msg_q, resets[7:0]});
        {btn_mute, btn_lamp_test, svc_expired} = 5'h0;
        step(2);
        chk(2'b00, {svc_done_msg_q, svc_request_q});
        clr();
        $display("test service done");
        for (i = 0; i < 10; i++) begin
            apply(i, 1'b1);
            step(150);
            chk(exp_t[i], {ld_flags_q, warn_flags_q});
            apply(i, 1'b0);
            clr();
        end
        $display("test single faults done");
        print_verdict;
    end
endmodule
